// ### rtl/ebtsp_timer.v
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ebtsp_consts.vh"
// Operation
// - 8-bit count register fed by an 8-bit divider shared with watchdog
// - timer mode with source bit 0 counts instruction cycles, every one only when the divider serves the watchdog
// - counting is held off two cycles after each count write
// - source bit 1 selects counting of external input edges
// - edge bit chooses rising or falling external edges
// - one divider serves counter or watchdog; assign bit 0 means counter
// - divider on counter gives eight ratios, 1:2 to 1:256
// - undivided counting only when divider belongs to the watchdog
// - divider count cannot be read or written by software
// - count write clears the divider while it serves the counter
// - watchdog clear also clears the divider while it serves the watchdog
// - wrap FFh to 00h sets overflow flag regardless of enable; software clears
// - edge bit 1 counts high-to-low, 0 low-to-high
// - assign bit 1 gives divider to watchdog, 0 to counter
module ebtsp_timer (
    input wire CLK_SYS,
    input wire RST_N,
    input wire INSTR_CYCLE,
    input wire EXTERNAL_COUNT_INPUT,
    input wire WATCHDOG_TICK_IN,
    output reg WATCHDOG_TICK,
    output reg WATCHDOG_CLEAR,
    output reg IRQ,
    input wire [31:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [31:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY
);
    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `EBTSP_OFF_COUNT) || (a == `EBTSP_OFF_OPTION) || (a == `EBTSP_OFF_INTCTL) ||
                     (a == `EBTSP_OFF_STATUS) || (a == `EBTSP_OFF_MASK) || (a == `EBTSP_OFF_CMD);
        end
    endfunction

    // register write hit: address match with byte lane 0 present
    function wr_hit;
        input wr;
        input lane;
        input [7:0] a;
        input [7:0] off;
        begin
            wr_hit = wr & lane & (a == off);
        end
    endfunction

    reg [`EBTSP_CNT_W-1:0] count_register;
    reg [7:0] option_control;
    reg [7:0] interrupt_control;
    reg [`EBTSP_EV_W-1:0] status;
    reg [`EBTSP_EV_W-1:0] mask;
    reg [1:0] inhibit;
    reg [31:0] aw_addr;
    reg [31:0] w_data;
    reg aw_held;
    reg w_held;
    reg w_lane0;

    wire count_source_select = option_control[`EBTSP_OPT_SRC];
    wire count_edge_select = option_control[`EBTSP_OPT_EDGE];
    wire divider_assign = option_control[`EBTSP_OPT_ASSIGN];
    wire [2:0] divider_rate = option_control[`EBTSP_OPT_RATE_HI:`EBTSP_OPT_RATE_LO];

    // write channel capture, either order
    wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
    wire w_take = S_AXI_WVALID & S_AXI_WREADY;
    wire aw_have = aw_held | aw_take;
    wire w_have = w_held | w_take;
    wire [7:0] wa = aw_take ? S_AXI_AWADDR[7:0] : aw_addr[7:0];
    wire [31:0] wd = w_take ? S_AXI_WDATA : w_data;
    wire do_write = aw_have & w_have & ~S_AXI_BVALID;
    wire wlane0 = w_take ? S_AXI_WSTRB[0] : w_lane0;
    wire wr_count = wr_hit(do_write, wlane0, wa, `EBTSP_OFF_COUNT);
    wire wr_option = wr_hit(do_write, wlane0, wa, `EBTSP_OFF_OPTION);
    wire wr_intctl = wr_hit(do_write, wlane0, wa, `EBTSP_OFF_INTCTL);
    wire wr_status = wr_hit(do_write, wlane0, wa, `EBTSP_OFF_STATUS);
    wire wr_mask = wr_hit(do_write, wlane0, wa, `EBTSP_OFF_MASK);
    wire wd_clear = wr_hit(do_write, wlane0, wa, `EBTSP_OFF_CMD) & wd[`EBTSP_CMD_WDCLR];

    // source selection
    wire ext_edge;
    ebtsp_edge_detect u_edge (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .pin(EXTERNAL_COUNT_INPUT),
        .falling(count_edge_select),
        .edge_pulse(ext_edge)
    );
    wire src_tick = count_source_select ? ext_edge : INSTR_CYCLE;

    // one divider, routed by the assign bit
    wire pre_in = divider_assign ? WATCHDOG_TICK_IN : src_tick;
    wire pre_clear = divider_assign ? wd_clear : wr_count;
    wire pre_out;
    ebtsp_prescaler u_pre (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .clear(pre_clear),
        .tick_in(pre_in),
        .rate(divider_rate),
        .to_wdt(divider_assign),
        .tick_out(pre_out)
    );
    // undivided only when the divider serves the watchdog
    wire cnt_tick = divider_assign ? src_tick : pre_out;
    wire wdt_tick = divider_assign ? pre_out : WATCHDOG_TICK_IN;

    wire inhibit_idle = (inhibit == `EBTSP_INHIBIT_NONE);
    wire cnt_inc = cnt_tick & inhibit_idle & ~wr_count;
    wire ovf = cnt_inc & (count_register == `EBTSP_CNT_MAX);
    wire [`EBTSP_EV_W-1:0] ev_set = {wdt_tick, ovf};
    wire [`EBTSP_EV_W-1:0] ev_clr = wr_status ? wd[`EBTSP_EV_W-1:0] : {`EBTSP_EV_W{1'b0}};

    // count register and its write inhibit window
    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            count_register <= {`EBTSP_CNT_W{1'b0}};
            inhibit <= `EBTSP_INHIBIT_NONE;
        end
        else if (wr_count)
        begin
            count_register <= wd[`EBTSP_CNT_W-1:0];
            inhibit <= `EBTSP_INHIBIT_CYC;
        end
        else
        begin
            if (cnt_inc)
                count_register <= count_register + `EBTSP_CNT_ONE;
            if (!inhibit_idle && INSTR_CYCLE)
                inhibit <= inhibit - `EBTSP_INHIBIT_STEP;
        end
    end

    // option control
    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            option_control <= `EBTSP_OPT_RESET;
        else if (wr_option)
            option_control <= wd[7:0];
    end

    // interrupt control; flag set wins over software clear
    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            interrupt_control <= `EBTSP_INT_RESET;
        else if (wr_intctl)
        begin
            interrupt_control <= wd[7:0];
            if (ovf)
                interrupt_control[`EBTSP_INT_FLAG] <= 1'b1;
        end
        else if (ovf)
            interrupt_control[`EBTSP_INT_FLAG] <= 1'b1;
    end

    // sticky event bits, set wins over write-one-to-clear
    wire [`EBTSP_EV_W-1:0] next_status;
    genvar i;
    generate
        for (i = 0; i < `EBTSP_EV_W; i = i + 1)
        begin : g_event
            assign next_status[i] = ev_set[i] | (status[i] & ~ev_clr[i]);
        end
    endgenerate

    // event status
    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            status <= {`EBTSP_EV_W{1'b0}};
        else
            status <= next_status;
    end

    // event mask
    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            mask <= {`EBTSP_EV_W{1'b0}};
        else if (wr_mask)
            mask <= wd[`EBTSP_EV_W-1:0];
    end

    // registered outputs
    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            WATCHDOG_TICK <= 1'b0;
            WATCHDOG_CLEAR <= 1'b0;
            IRQ <= 1'b0;
        end
        else
        begin
            WATCHDOG_TICK <= wdt_tick;
            WATCHDOG_CLEAR <= wd_clear;
            IRQ <= |(status & mask);
        end
    end

    // axi write side
    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 32'h00000000;
            w_data <= 32'h00000000;
            w_lane0 <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `EBTSP_RESP_OKAY;
        end
        else
        begin
            S_AXI_AWREADY <= ~aw_have & ~S_AXI_BVALID & ~S_AXI_AWREADY;
            S_AXI_WREADY <= ~w_have & ~S_AXI_BVALID & ~S_AXI_WREADY;
            if (aw_take)
                aw_addr <= S_AXI_AWADDR;
            if (w_take)
            begin
                w_data <= S_AXI_WDATA;
                w_lane0 <= S_AXI_WSTRB[0];
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                S_AXI_AWREADY <= 1'b0;
                S_AXI_WREADY <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= mapped(wa) ? `EBTSP_RESP_OKAY : `EBTSP_RESP_SLVERR;
            end
            else
            begin
                aw_held <= aw_have;
                w_held <= w_have;
                if (S_AXI_BVALID && S_AXI_BREADY)
                    S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // axi read side; divider count has no address
    reg [31:0] next_rdata;
    always @*
    begin
        next_rdata = 32'h00000000;
        case (S_AXI_ARADDR[7:0])
            `EBTSP_OFF_COUNT: next_rdata = {24'h000000, count_register};
            `EBTSP_OFF_OPTION: next_rdata = {24'h000000, option_control};
            `EBTSP_OFF_INTCTL: next_rdata = {24'h000000, interrupt_control};
            `EBTSP_OFF_STATUS: next_rdata = {{(32-`EBTSP_EV_W){1'b0}}, status};
            `EBTSP_OFF_MASK: next_rdata = {{(32-`EBTSP_EV_W){1'b0}}, mask};
            default: next_rdata = 32'h00000000;
        endcase
    end

    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `EBTSP_RESP_OKAY;
        end
        else
        begin
            S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY)
            begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= next_rdata;
                S_AXI_RRESP <= mapped(S_AXI_ARADDR[7:0]) ? `EBTSP_RESP_OKAY : `EBTSP_RESP_SLVERR;
            end
            else if (S_AXI_RVALID && S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
        end
    end
endmodule // ebtsp_timer

// ### rtl/ebtsp_consts.vh
`ifndef EBTSP_CONSTS_VH
`define EBTSP_CONSTS_VH
// register byte offsets
`define EBTSP_OFF_COUNT 8'h00
`define EBTSP_OFF_OPTION 8'h04
`define EBTSP_OFF_INTCTL 8'h08
`define EBTSP_OFF_STATUS 8'h0C
`define EBTSP_OFF_MASK 8'h10
`define EBTSP_OFF_CMD 8'h14
// option_control fields
`define EBTSP_OPT_RESET 8'hFF
`define EBTSP_OPT_SRC 5
`define EBTSP_OPT_EDGE 4
`define EBTSP_OPT_ASSIGN 3
`define EBTSP_OPT_RATE_HI 2
`define EBTSP_OPT_RATE_LO 0
// interrupt_control fields
`define EBTSP_INT_RESET 8'h00
`define EBTSP_INT_ENABLE 5
`define EBTSP_INT_FLAG 2
// command register: bit 0 is the watchdog clear
`define EBTSP_CMD_WDCLR 0
// status / mask: bit 0 overflow event, bit 1 watchdog tick event
`define EBTSP_EV_OVF 0
`define EBTSP_EV_WDT 1
`define EBTSP_EV_W 2
// misc
`define EBTSP_INHIBIT_CYC 2'h2
`define EBTSP_PRE_W 8
`define EBTSP_CNT_W 8
`define EBTSP_CNT_MAX 8'hFF
`define EBTSP_CNT_ONE 8'h01
`define EBTSP_INHIBIT_NONE 2'h0
`define EBTSP_INHIBIT_STEP 2'h1
`define EBTSP_RESP_OKAY 2'h0
`define EBTSP_RESP_SLVERR 2'h2
`endif

// ### rtl/ebtsp_prescaler.v
`timescale 1ns/1ps
`include "ebtsp_consts.vh"
// shared 8-bit divider, count never visible to software
module ebtsp_prescaler (
    input wire clk,
    input wire rst_n,
    input wire clear,
    input wire tick_in,
    input wire [2:0] rate,
    input wire to_wdt,
    output reg tick_out
);
    reg [`EBTSP_PRE_W-1:0] count;
    reg [`EBTSP_PRE_W-1:0] next_count;
    wire [3:0] shift;
    wire [`EBTSP_PRE_W:0] period;
    // counter divides by 2^(n+1), watchdog by 2^n
    assign shift = to_wdt ? {1'b0, rate} : {1'b0, rate} + 4'h1;
    assign period = {{`EBTSP_PRE_W{1'b0}}, 1'b1} << shift;
    wire wrap = (({1'b0, count} + {{`EBTSP_PRE_W{1'b0}}, 1'b1}) == period);
    always @*
    begin
        next_count = count;
        if (tick_in)
            next_count = wrap ? {`EBTSP_PRE_W{1'b0}} : count + 8'h01;
    end
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= {`EBTSP_PRE_W{1'b0}};
            tick_out <= 1'b0;
        end
        else if (clear)
        begin
            count <= {`EBTSP_PRE_W{1'b0}};
            tick_out <= 1'b0;
        end
        else
        begin
            count <= next_count;
            tick_out <= tick_in & wrap;
        end
    end
endmodule // ebtsp_prescaler

// ### rtl/ebtsp_edge_detect.v
`timescale 1ns/1ps
`include "ebtsp_consts.vh"
// chosen edge of the external count input
module ebtsp_edge_detect (
    input wire clk,
    input wire rst_n,
    input wire pin,
    input wire falling,
    output reg edge_pulse
);
    reg last;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last <= 1'b0;
            edge_pulse <= 1'b0;
        end
        else
        begin
            last <= pin;
            // 1 picks high-to-low, 0 low-to-high
            edge_pulse <= falling ? (last & ~pin) : (~last & pin);
        end
    end
endmodule // ebtsp_edge_detect

// ### verif/ebtsp_ext_src.sv
`timescale 1ns/1ps
module ebtsp_ext_src (
    input wire clk,
    output reg pin
);
    initial pin = 1'b0;
    // level held between bursts, one toggle every third clock
    task toggle(input int n);
        repeat (n)
        begin
            repeat (3) @(posedge clk);
            pin <= ~pin;
        end
    endtask
endmodule // ebtsp_ext_src

// ### verif/ebtsp_assertions.sv
`timescale 1ns/1ps
`include "ebtsp_consts.vh"
module ebtsp_assertions (
    input wire CLK_SYS,
    input wire RST_N,
    input wire WATCHDOG_TICK_IN,
    input wire WATCHDOG_TICK,
    input wire WATCHDOG_CLEAR,
    input wire IRQ,
    input wire [31:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    input wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    input wire S_AXI_WREADY,
    input wire [1:0] S_AXI_BRESP,
    input wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [31:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    input wire S_AXI_ARREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    input wire [1:0] S_AXI_RRESP
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    sequence wr_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence rd_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    a_clear_pulse: assert property (
        (wr_taken ##0 (S_AXI_AWADDR[7:0] == `EBTSP_OFF_CMD && S_AXI_WDATA[0] && S_AXI_WSTRB[0]))
        |-> ##[1:2] WATCHDOG_CLEAR) else $error("watchdog clear not issued");
    a_write_resp: assert property (wr_taken |=> S_AXI_BVALID) else $error("no write response");
    a_read_lat: assert property (rd_taken |=> S_AXI_RVALID) else $error("no read data");
    a_resp_hold: assert property (
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bresp dropped");
    a_rdata_hold: assert property (
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("rdata dropped");
    a_unmapped_err: assert property (
        (rd_taken ##0 S_AXI_ARADDR == 32'h40) |=> S_AXI_RRESP == `EBTSP_RESP_SLVERR && S_AXI_RDATA == 32'h0)
        else $error("unmapped read not refused");
    a_wdt_tick: assert property (
        WATCHDOG_TICK |-> $past(WATCHDOG_TICK_IN) || $past(WATCHDOG_TICK_IN, 2) || $past(WATCHDOG_TICK_IN, 3))
        else $error("watchdog tick without input");
    a_irq_swclear: assert property (
        $fell(IRQ) |-> $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2) || $past(S_AXI_BVALID, 3))
        else $error("irq fell without write");
endmodule // ebtsp_assertions
bind ebtsp_timer ebtsp_assertions chk (.CLK_SYS, .RST_N, .WATCHDOG_TICK_IN, .WATCHDOG_TICK, .WATCHDOG_CLEAR, .IRQ,
    .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RRESP);

// ### verif/test_ebtsp_timer.sv
`timescale 1ns/1ps
`include "ebtsp_consts.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_eight_bit_timer_shared_prescaler;
    reg clk = 0, rst_n = 0, ic = 0, wti = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    reg [31:0] awa = 0, wd = 0, ara = 0, q;
    reg [1:0] qr;
    reg [3:0] ws = 4'hF;
    wire ext, wtk, wclr, irq, awr, wr, bv, arr, rv;
    wire [1:0] bresp, rresp;
    wire [31:0] rd;
    int err_total = 0, checks = 0, seed = 46, r, e, m, c, v, lv, wtk_n = 0, wclr_n = 0;
    always #2 clk = ~clk;
    always @(posedge clk) if (wtk === 1'b1) wtk_n <= wtk_n + 1;
    always @(posedge clk) if (wclr === 1'b1) wclr_n <= wclr_n + 1;
    ebtsp_ext_src src (.clk(clk), .pin(ext));
    ebtsp_timer dut (.CLK_SYS(clk), .RST_N(rst_n), .INSTR_CYCLE(ic), .EXTERNAL_COUNT_INPUT(ext),
        .WATCHDOG_TICK_IN(wti), .WATCHDOG_TICK(wtk), .WATCHDOG_CLEAR(wclr), .IRQ(irq),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
    task wrap_up;
        $display("checks=%0d mismatches=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // one bus transfer, ready raised after a random delay
    task bus(input bit w, input [7:0] a, input [31:0] d);
        int k, dl, ok;
        dl = $unsigned($random(seed)) % 3;
        ok = 0;
        @(posedge clk);
        if (w)
        begin
            awa <= {24'h0, a};
            wd <= d;
            awv <= 1;
            wv <= 1;
        end
        else
        begin
            ara <= {24'h0, a};
            arv <= 1;
        end
        for (k = 0; k < 60 && !ok; k++)
        begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wr) wv <= 0;
            if (arr) arv <= 0;
            if (k == dl) br <= w;
            if (k == dl) rr <= !w;
            if ((bv && br) || (rv && rr))
            begin
                ok = 1;
                q = rd;
                qr = w ? bresp : rresp;
                br <= 0;
                rr <= 0;
            end
        end
        if (!ok)
        begin
            err_total++;
            wrap_up;
        end
    endtask
    task rdchk(input [7:0] a, input [31:0] x);
        bus(0, a, 0);
        `CHK(q, x)
    endtask
    task pulse(input bit t, input int n);
        repeat (n)
        begin
            @(posedge clk);
            if (t) wti <= 1; else ic <= 1;
            @(posedge clk);
            wti <= 0;
            ic <= 0;
        end
        repeat (5) @(posedge clk);
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1;
        rdchk(`EBTSP_OFF_OPTION, 32'hFF);
        rdchk(`EBTSP_OFF_INTCTL, 32'h0);
        bus(0, 8'h40, 0);
        `CHK(qr, `EBTSP_RESP_SLVERR)
        bus(1, `EBTSP_OFF_OPTION, 32'h08);
        v = $random(seed) & 255;
        bus(1, `EBTSP_OFF_COUNT, v);
        rdchk(`EBTSP_OFF_COUNT, v);
        ws <= 4'h0;
        bus(1, `EBTSP_OFF_COUNT, v ^ 32'hFF);
        ws <= 4'hF;
        rdchk(`EBTSP_OFF_COUNT, v);
        bus(1, `EBTSP_OFF_MASK, 1);
        bus(1, `EBTSP_OFF_COUNT, 32'hFE);
        pulse(0, 6);
        rdchk(`EBTSP_OFF_COUNT, (8'hFE + 6 - 2) & 255);
        rdchk(`EBTSP_OFF_INTCTL, 32'h04);
        `CHK(irq, 1'b1)
        bus(1, `EBTSP_OFF_MASK, 0);
        pulse(0, 0);
        `CHK(irq, 1'b0)
        bus(1, `EBTSP_OFF_MASK, 1);
        pulse(0, 0);
        `CHK(irq, 1'b1)
        bus(1, `EBTSP_OFF_STATUS, 1);
        pulse(0, 0);
        `CHK(irq, 1'b0)
        bus(1, `EBTSP_OFF_INTCTL, 32'h20);
        rdchk(`EBTSP_OFF_INTCTL, 32'h20);
        $display("test registers and overflow done");
        for (r = 0; r < 8; r++)
        begin
            bus(1, `EBTSP_OFF_CMD, 1);
            bus(1, `EBTSP_OFF_COUNT, 0);
            bus(1, `EBTSP_OFF_OPTION, 32'h08 | r);
            bus(1, `EBTSP_OFF_CMD, 1);
            pulse(0, 2);
            bus(1, `EBTSP_OFF_CMD, 1);
            bus(1, `EBTSP_OFF_OPTION, r);
            pulse(0, (2 << r) * 2 - 1);
            rdchk(`EBTSP_OFF_COUNT, 1);
        end
        m = wtk_n;
        pulse(1, 3);
        `CHK(wtk_n - m, 3)
        $display("test counter divider done");
        for (r = 0; r < 4; r++)
        begin
            c = wclr_n;
            bus(1, `EBTSP_OFF_CMD, 1);
            bus(1, `EBTSP_OFF_COUNT, 0);
            bus(1, `EBTSP_OFF_OPTION, 32'h08 | r);
            bus(1, `EBTSP_OFF_CMD, 1);
            m = wtk_n;
            pulse(1, 3 * (1 << r) - 1);
            `CHK(wtk_n - m, 2)
            `CHK(wclr_n - c, 2)
        end
        rdchk(`EBTSP_OFF_STATUS, 32'h2);
        $display("test watchdog divider done");
        for (e = 0; e < 2; e++)
        begin
            bus(1, `EBTSP_OFF_OPTION, 32'h28 | (e << 4));
            bus(1, `EBTSP_OFF_COUNT, 0);
            pulse(0, 2);
            lv = ext;
            src.toggle(5);
            pulse(0, 0);
            rdchk(`EBTSP_OFF_COUNT, (lv == e) ? 3 : 2);
        end
        $display("test external edges done");
        wrap_up;
    end
endmodule // test_eight_bit_timer_shared_prescaler
